// ### dv/analog_front_model.sv
`timescale 1ns/100ps
module analog_front_model (
   // clock
   input wire logic clock,
   // converter side
   input wire logic [9:0] trial_code,
   input wire logic [7:0] analogue_inputs_sel,
   // input levels in code steps
   input wire logic [7:0][9:0] levels,
   output logic comp_in
);
   logic [10:0] vin_half;
   logic [3:0] hits;
   logic float_reg = 1'b0;
   always_comb begin
      vin_half = 11'h000;
      hits = 4'h0;
      for (int i = 0; i < 8; i++) begin
         if (analogue_inputs_sel[i]) begin
            vin_half = {levels[i], 1'b1};
            hits = hits + 4'h1;
         end
      end
   end
   // half-step offset keeps the compare away from ties
   assign comp_in = (hits == 4'h1) ? (vin_half > {trial_code, 1'b0}) : float_reg;
   // an unselected input floats, so the comparator wanders
   always @(posedge clock) begin
      float_reg <= ~float_reg;
   end
endmodule

// ### dv/sar_adc_control_tb_top.sv
`timescale 1ns/100ps
module sar_adc_control_tb_top;
   localparam logic [15:0] A_RES = sar_adc_pkg::RESULT_ADDR;
   localparam logic [15:0] A_MODE = sar_adc_pkg::MODE_ADDR;
   localparam logic [15:0] A_ST = sar_adc_pkg::START_ADDR;
   localparam logic [15:0] A_PB = sar_adc_pkg::PORTB_FUNC_ADDR;
   localparam logic [15:0] A_EDGE = sar_adc_pkg::EDGE_ADDR;
   localparam logic [15:0] A_CLK = sar_adc_pkg::CLK_STOP1_ADDR;
   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   logic [15:0] reg_addr = 16'h0000;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic ext_trigger_pin = 1'b0;
   logic [7:0][9:0] levels = '0;
   logic [15:0] reg_rdata;
   logic comp_in;
   logic [9:0] trial_code;
   logic [7:0] analogue_inputs_sel;
   logic converter_powered;
   logic [2:0] port_b_intr_enable;
   integer seed = 29020;
   integer miscompares = 0;
   integer samples_checked = 0;
   logic [15:0] last_res;
   logic [15:0] d;
   logic [9:0] tv;

   sar_adc_control i_dut (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_trigger_pin(ext_trigger_pin),
      .comp_in(comp_in), .trial_code(trial_code), .analogue_inputs_sel(analogue_inputs_sel),
      .converter_powered(converter_powered), .port_b_intr_enable(port_b_intr_enable));
   analog_front_model i_front (.clock(clock), .trial_code(trial_code),
      .analogue_inputs_sel(analogue_inputs_sel), .levels(levels), .comp_in(comp_in));

   initial begin
      forever #20 clock = ~clock;
   end

   function automatic logic [15:0] res_word(input logic [9:0] v);
      res_word = {v, 6'h00};
   endfunction

   function automatic logic [15:0] mode_word(input logic fast, input logic ext_trigger_allow, input logic [3:0] ch);
      mode_word = {8'h00, fast, ext_trigger_allow, 2'b00, ch};
   endfunction

   task automatic conclude;
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
         miscompares = miscompares + 1;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
   endtask

   task automatic wr(input logic [15:0] a, input logic [15:0] v);
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [15:0] a, output logic [15:0] v);
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      @(negedge clock);
      v = reg_rdata;
   endtask

   task automatic rdc(input logic [15:0] a, input logic [15:0] exp);
      logic [15:0] v;
      rd(a, v);
      chk(v, exp);
   endtask

   task automatic sel_chk(input logic [7:0] exp);
      @(negedge clock);
      chk({8'h00, analogue_inputs_sel}, {8'h00, exp});
   endtask

   task automatic wait_idle;
      logic [15:0] v;
      v = 16'h0080;
      for (int k = 0; k < 80 && v !== 16'h0000; k++) begin
         rd(A_ST, v);
      end
      if (v !== 16'h0000) begin
         miscompares = miscompares + 1;
         conclude();
      end
   endtask

   task automatic conv(input int ch, input logic fast);
      logic [9:0] v;
      v = 10'($random(seed));
      levels[ch] = v;
      wr(A_MODE, mode_word(fast, 1'b0, 4'(ch + 4)));
      sel_chk(8'h01 << ch);
      wr(A_ST, 16'h0080);
      cyc(fast ? 28 : 59);
      rdc(A_ST, 16'h0080);
      rdc(A_ST, 16'h0000);
      rdc(A_RES, res_word(v));
      wr(A_RES, ~res_word(v));
      rdc(A_RES, res_word(v));
      last_res = res_word(v);
   endtask

   initial begin
      repeat (100000) @(posedge clock);
      miscompares = miscompares + 1;
      conclude();
   end

   initial begin
      repeat (6) @(posedge clock);
      sys_rst <= 1'b0;
      rdc(A_MODE, 16'h0000);
      rdc(A_ST, 16'h0000);
      rdc(A_PB, 16'h0000);
      rdc(A_EDGE, 16'h0000);
      rdc(A_CLK, 16'h0001);
      rdc(16'hff00, 16'h0000);
      repeat (4) begin
         d = 16'($random(seed));
         wr(A_MODE, d);
         rdc(A_MODE, d & 16'h00cf);
      end
      for (int ch = 0; ch < 8; ch++) begin
         conv(ch, 1'($random(seed)));
      end
      conv(2, 1'b0);
      conv(6, 1'b1);
      // forced stop keeps the old result
      wr(A_MODE, mode_word(1'b1, 1'b0, 4'h4));
      wr(A_ST, 16'h0080);
      cyc(8);
      wr(A_ST, 16'h0040);
      rdc(A_ST, 16'h0000);
      rdc(A_RES, last_res);
      // standby aborts and blocks starts
      wr(A_ST, 16'h0080);
      cyc(8);
      wr(A_CLK, 16'h0000);
      rdc(A_ST, 16'h0000);
      chk({15'h0000, converter_powered}, 16'h0000);
      wr(A_ST, 16'h0080);
      rdc(A_ST, 16'h0000);
      rdc(A_RES, last_res);
      wr(A_CLK, 16'h0001);
      rdc(A_CLK, 16'h0001);
      chk({15'h0000, converter_powered}, 16'h0001);
      cyc(10);
      conv(4, 1'b1);
      // port B pins given to the interrupt function
      wr(A_PB, 16'h0007);
      rdc(A_PB, 16'h0007);
      chk({13'h0000, port_b_intr_enable}, 16'h0007);
      wr(A_MODE, mode_word(1'b1, 1'b0, 4'h4));
      sel_chk(8'h00);
      wr(A_MODE, mode_word(1'b1, 1'b0, 4'h7));
      sel_chk(8'h08);
      wr(A_PB, 16'h0000);
      wr(A_MODE, mode_word(1'b1, 1'b0, 4'hc));
      sel_chk(8'h00);
      wr(A_MODE, mode_word(1'b1, 1'b0, 4'h2));
      sel_chk(8'h00);
      // external trigger, rising then falling edge
      tv = 10'($random(seed));
      levels[1] <= tv;
      wr(A_MODE, mode_word(1'b1, 1'b1, 4'h5));
      ext_trigger_pin <= 1'b1;
      cyc(8);
      rdc(A_ST, 16'h0080);
      wait_idle();
      rdc(A_RES, res_word(tv));
      ext_trigger_pin <= 1'b0;
      cyc(8);
      rdc(A_ST, 16'h0000);
      wr(A_EDGE, 16'h0080);
      rdc(A_EDGE, 16'h0080);
      ext_trigger_pin <= 1'b1;
      cyc(8);
      rdc(A_ST, 16'h0000);
      ext_trigger_pin <= 1'b0;
      cyc(8);
      rdc(A_ST, 16'h0080);
      wait_idle();
      wr(A_MODE, mode_word(1'b1, 1'b0, 4'h5));
      ext_trigger_pin <= 1'b1;
      cyc(8);
      ext_trigger_pin <= 1'b0;
      cyc(8);
      rdc(A_ST, 16'h0000);
      wr(A_CLK, 16'h0000);
      conclude();
   end
endmodule

// ### hdl/sar_adc_control.sv
`timescale 1ns/100ps
module sar_adc_control #(
   parameter int ADDR_W = 16,
   parameter int DATA_W = 16
) (
   // clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // register port
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [DATA_W-1:0] reg_rdata,
   // trigger pin
   input wire logic ext_trigger_pin,
   // analogue front end
   input wire logic comp_in,
   output logic [9:0] trial_code,
   output logic [7:0] analogue_inputs_sel,
   output logic converter_powered,
   // port B routing
   output logic [2:0] port_b_intr_enable
);
   localparam int RW = sar_adc_pkg::RESULT_W;

   logic [7:0] converter_mode_reg;
   logic [2:0] port_b_function_reg;
   logic converter_clock_run_bit;
   logic trigger_edge_select;
   logic [RW-1:0] result_reg;
   logic [DATA_W-1:0] rdata_reg, rdata_next;

   logic wr_result, wr_mode, wr_start, wr_portb, wr_edge, wr_clk;
   logic rd_result, rd_mode, rd_start, rd_portb, rd_edge, rd_clk;
   logic sw_go, sw_stop, abort, trig_edge, trig_go, accept;
   logic trig_rise, trig_fall;
   logic conversion_active_flag, conv_done;
   logic [RW-1:0] final_code;
   logic fast_sel, trig_allow;
   logic [3:0] chan_field;
   logic [7:0] chan_onehot;

   // address decode
   assign wr_result = reg_wr && (reg_addr == sar_adc_pkg::RESULT_ADDR);
   assign wr_mode = reg_wr && (reg_addr == sar_adc_pkg::MODE_ADDR);
   assign wr_start = reg_wr && (reg_addr == sar_adc_pkg::START_ADDR);
   assign wr_portb = reg_wr && (reg_addr == sar_adc_pkg::PORTB_FUNC_ADDR);
   assign wr_edge = reg_wr && (reg_addr == sar_adc_pkg::EDGE_ADDR);
   assign wr_clk = reg_wr && (reg_addr == sar_adc_pkg::CLK_STOP1_ADDR);
   assign rd_result = reg_rd && (reg_addr == sar_adc_pkg::RESULT_ADDR);
   assign rd_mode = reg_rd && (reg_addr == sar_adc_pkg::MODE_ADDR);
   assign rd_start = reg_rd && (reg_addr == sar_adc_pkg::START_ADDR);
   assign rd_portb = reg_rd && (reg_addr == sar_adc_pkg::PORTB_FUNC_ADDR);
   assign rd_edge = reg_rd && (reg_addr == sar_adc_pkg::EDGE_ADDR);
   assign rd_clk = reg_rd && (reg_addr == sar_adc_pkg::CLK_STOP1_ADDR);

   // mode fields
   // time select
   assign fast_sel = converter_mode_reg[sar_adc_pkg::MODE_CKS_BIT];
   assign trig_allow = converter_mode_reg[sar_adc_pkg::MODE_EXT_TRIGGER_ALLOW_BIT];
   assign chan_field = converter_mode_reg[sar_adc_pkg::MODE_CH_LSB +: sar_adc_pkg::MODE_CH_W];

   assign chan_onehot = sar_adc_pkg::chan_decode(chan_field);
   // pins in interrupt function are cut from the mux
   assign analogue_inputs_sel = converter_clock_run_bit ? (chan_onehot & ~{5'h00, port_b_function_reg}) : 8'h00;
   assign port_b_intr_enable = port_b_function_reg;
   assign converter_powered = converter_clock_run_bit;

   assign sw_go = wr_start && reg_wdata[sar_adc_pkg::START_GO_BIT];
   assign sw_stop = wr_start && reg_wdata[sar_adc_pkg::START_STOP_BIT];
   assign abort = sw_stop || !converter_clock_run_bit;
   assign trig_edge = trigger_edge_select ? trig_fall : trig_rise;
   assign trig_go = trig_allow && trig_edge;
   // a start from either source, when idle and not aborting, sets the active flag via the engine
   assign accept = (sw_go || trig_go) && !abort && !conversion_active_flag;

   trig_edge_sync u_trig (
      .clock(clock),
      .sys_rst(sys_rst),
      .pin_in(ext_trigger_pin),
      .rise(trig_rise),
      .fall(trig_fall)
   );

   sar_engine #(.RES_W(RW)) u_sar (
      .clock(clock),
      .sys_rst(sys_rst),
      .start(accept),
      .abort(abort),
      .fast(fast_sel),
      .comp_in(comp_in),
      .busy(conversion_active_flag),
      .done(conv_done),
      .trial_code(trial_code),
      .final_code(final_code)
   );

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         converter_mode_reg <= sar_adc_pkg::MODE_RESET;
         port_b_function_reg <= sar_adc_pkg::PORTB_FUNC_RESET;
         converter_clock_run_bit <= sar_adc_pkg::CLK_RUN_RESET;
         trigger_edge_select <= sar_adc_pkg::EDGE_SEL_RESET;
      end else begin
         if (wr_mode) begin
            converter_mode_reg <= reg_wdata[7:0] & 8'hcf;
         end
         if (wr_portb) begin
            port_b_function_reg <= reg_wdata[2:0];
         end
         // write 1 leaves standby, 0 enters it
         if (wr_clk) begin
            converter_clock_run_bit <= reg_wdata[sar_adc_pkg::CLK_RUN_BIT];
         end
         if (wr_edge) begin
            trigger_edge_select <= reg_wdata[sar_adc_pkg::EDGE_SEL_BIT];
         end
      end
   end

   // no reset; loads only at completion
   always_ff @(posedge clock) begin
      if (conv_done) begin
         result_reg <= final_code;
      end
   end

   // readable any time
   // read mux; result in upper bits, low bits zero
   always_comb begin
      rdata_next = '0;
      if (rd_result) begin
         rdata_next[sar_adc_pkg::RESULT_LSB +: RW] = result_reg;
      end else if (rd_mode) begin
         rdata_next[7:0] = converter_mode_reg;
      end else if (rd_start) begin
         rdata_next[sar_adc_pkg::START_GO_BIT] = conversion_active_flag;
      end else if (rd_portb) begin
         rdata_next[2:0] = port_b_function_reg;
      end else if (rd_edge) begin
         rdata_next[sar_adc_pkg::EDGE_SEL_BIT] = trigger_edge_select;
      end else if (rd_clk) begin
         rdata_next[sar_adc_pkg::CLK_RUN_BIT] = converter_clock_run_bit;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         rdata_reg <= '0;
      end else begin
         rdata_reg <= rdata_next;
      end
   end
   assign reg_rdata = rdata_reg;

   // helper: age of the running conversion and its time setting
   logic [6:0] age_reg;
   logic fast_at_start_reg;
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         age_reg <= 7'h00;
         fast_at_start_reg <= 1'b0;
      end else if (accept) begin
         age_reg <= 7'h00;
         fast_at_start_reg <= fast_sel;
      end else if (conversion_active_flag) begin
         age_reg <= age_reg + 7'h01;
      end
   end

   // helper: result holds a completed value, so hold checks skip the unset power-up content
   logic result_loaded_reg;
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         result_loaded_reg <= 1'b0;
      end else if (conv_done) begin
         result_loaded_reg <= 1'b1;
      end
   end

   property p_fast_time;
      @(posedge clock) disable iff (sys_rst)
      (conv_done && fast_at_start_reg) |-> (age_reg == 7'(sar_adc_pkg::CONV_STATES_FAST - 1));
   endproperty
   a_fast_time: assert property (p_fast_time) else $error("fast conversion length wrong");

   property p_slow_time;
      @(posedge clock) disable iff (sys_rst)
      (conv_done && !fast_at_start_reg) |-> (age_reg == 7'(sar_adc_pkg::CONV_STATES_SLOW - 1));
   endproperty
   a_slow_time: assert property (p_slow_time) else $error("slow conversion length wrong");

   property p_result_low_zero;
      @(posedge clock) disable iff (sys_rst)
      rd_result |=> (reg_rdata[5:0] == 6'h00 && reg_rdata[15:6] == $past(result_reg));
   endproperty
   a_result_low_zero: assert property (p_result_low_zero) else $error("result read layout wrong");

   property p_result_upper;
      @(posedge clock) disable iff (sys_rst)
      conv_done |=> (result_reg == $past(final_code));
   endproperty
   a_result_upper: assert property (p_result_upper) else $error("result not stored");

   property p_result_ro;
      @(posedge clock) disable iff (sys_rst)
      (result_loaded_reg && wr_result && !conv_done) |=> $stable(result_reg);
   endproperty
   a_result_ro: assert property (p_result_ro) else $error("result changed by write");

   property p_result_hold;
      @(posedge clock) disable iff (sys_rst)
      (result_loaded_reg && !conversion_active_flag && !accept) |=> $stable(result_reg);
   endproperty
   a_result_hold: assert property (p_result_hold) else $error("result changed while idle");

   property p_start_sets;
      @(posedge clock) disable iff (sys_rst)
      (sw_go && !abort && !conversion_active_flag) |=> conversion_active_flag;
   endproperty
   a_start_sets: assert property (p_start_sets) else $error("start did not set active flag");

   property p_done_clears;
      @(posedge clock) disable iff (sys_rst)
      conv_done |=> !conversion_active_flag;
   endproperty
   a_done_clears: assert property (p_done_clears) else $error("flag not cleared at completion");

   property p_stop_clears;
      @(posedge clock) disable iff (sys_rst)
      (sw_stop && conversion_active_flag) |=> !conversion_active_flag ##1 !conversion_active_flag;
   endproperty
   a_stop_clears: assert property (p_stop_clears) else $error("forced stop ignored");

   property p_trigger_start;
      @(posedge clock) disable iff (sys_rst)
      (trig_allow && trig_edge && !abort && !conversion_active_flag) |=> conversion_active_flag;
   endproperty
   a_trigger_start: assert property (p_trigger_start) else $error("trigger edge did not start");

   property p_standby;
      @(posedge clock) disable iff (sys_rst)
      !converter_clock_run_bit |-> (analogue_inputs_sel == 8'h00) ##1 !conversion_active_flag;
   endproperty
   a_standby: assert property (p_standby) else $error("converter active in standby");

   property p_prohibited_chan;
      @(posedge clock) disable iff (sys_rst)
      (chan_field[3:2] == 2'b11 || chan_field[3:2] == 2'b00) |-> (analogue_inputs_sel == 8'h00);
   endproperty
   a_prohibited_chan: assert property (p_prohibited_chan) else $error("invalid channel selected input");

   property p_portb_route;
      @(posedge clock) disable iff (sys_rst)
      port_b_function_reg[0] |-> !analogue_inputs_sel[0];
   endproperty
   a_portb_route: assert property (p_portb_route) else $error("interrupt pin routed to mux");

   property p_mode_write;
      @(posedge clock) disable iff (sys_rst)
      wr_mode |=> (converter_mode_reg == ($past(reg_wdata[7:0]) & 8'hcf));
   endproperty
   a_mode_write: assert property (p_mode_write) else $error("mode write not stored");

   property p_run_write;
      @(posedge clock) disable iff (sys_rst)
      wr_clk |=> (converter_clock_run_bit == $past(reg_wdata[sar_adc_pkg::CLK_RUN_BIT]));
   endproperty
   a_run_write: assert property (p_run_write) else $error("run bit write not stored");

   property p_one_input;
      @(posedge clock) disable iff (sys_rst)
      $onehot0(analogue_inputs_sel);
   endproperty
   a_one_input: assert property (p_one_input) else $error("more than one input selected");

   property p_rdata_idle;
      @(posedge clock) disable iff (sys_rst)
      !reg_rd |=> (reg_rdata == '0);
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside answer cycle");
endmodule

// ### hdl/sar_adc_pkg.sv
package sar_adc_pkg;

   // register addresses
   localparam logic [15:0] RESULT_ADDR = 16'hffbc;
   localparam logic [15:0] MODE_ADDR = 16'hffbe;
   localparam logic [15:0] START_ADDR = 16'hffc4;
   localparam logic [15:0] PORTB_FUNC_ADDR = 16'hffca;
   localparam logic [15:0] EDGE_ADDR = 16'hfff2;
   localparam logic [15:0] CLK_STOP1_ADDR = 16'hfffa;

   // mode register fields
   localparam int MODE_CKS_BIT = 7;
   localparam int MODE_EXT_TRIGGER_ALLOW_BIT = 6;
   localparam int MODE_CH_LSB = 0;
   localparam int MODE_CH_W = 4;
   localparam logic [7:0] MODE_RESET = 8'h00;

   // start register fields
   localparam int START_GO_BIT = 7;
   localparam int START_STOP_BIT = 6;

   // other register fields
   localparam int EDGE_SEL_BIT = 7;
   localparam int CLK_RUN_BIT = 0;
   localparam logic CLK_RUN_RESET = 1'b1;
   localparam logic [2:0] PORTB_FUNC_RESET = 3'h0;
   localparam logic EDGE_SEL_RESET = 1'b0;

   // result layout: 10 bits at the top, 6 zero bits below
   localparam int RESULT_W = 10;
   localparam int RESULT_LSB = 6;

   // conversion timing in states (one state is one clock)
   localparam int CONV_STATES_SLOW = 62;
   localparam int CONV_STATES_FAST = 31;
   localparam int SAMPLE_FAST = 11;
   localparam int TRIAL_FAST = 2;
   localparam int SAMPLE_SLOW = 22;
   localparam int TRIAL_SLOW = 4;

   typedef enum {ST_IDLE, ST_SAMPLE, ST_TRIAL} sar_state_t;

   function automatic logic [5:0] sample_len(input logic fast);
      sample_len = fast ? 6'(SAMPLE_FAST) : 6'(SAMPLE_SLOW);
   endfunction

   function automatic logic [5:0] trial_len(input logic fast);
      trial_len = fast ? 6'(TRIAL_FAST) : 6'(TRIAL_SLOW);
   endfunction

   // channel field to one-hot mux select; 00xx and 11xx select nothing
   function automatic logic [7:0] chan_decode(input logic [3:0] ch);
      chan_decode = 8'h00;
      if (ch[3] != ch[2]) begin
         chan_decode[{ch[3], ch[1:0]}] = 1'b1;
      end
   endfunction

endpackage

// ### hdl/sar_engine.sv
`timescale 1ns/100ps
module sar_engine #(
   parameter int RES_W = 10
) (
   // clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // control
   input wire logic start,
   input wire logic abort,
   input wire logic fast,
   // comparator, high when input exceeds trial code
   input wire logic comp_in,
   // status and data
   output logic busy,
   output logic done,
   output logic [RES_W-1:0] trial_code,
   output logic [RES_W-1:0] final_code
);
   sar_adc_pkg::sar_state_t state_reg, state_next;
   logic [5:0] cnt_reg, cnt_next;
   logic [3:0] bit_reg, bit_next;
   logic [RES_W-1:0] code_reg, code_next;
   logic fast_reg, fast_next;
   logic [RES_W-1:0] decided;

   assign busy = (state_reg != sar_adc_pkg::ST_IDLE);
   assign trial_code = code_reg;

   // keep or drop the bit under trial
   always_comb begin
      decided = code_reg;
      decided[bit_reg] = comp_in;
   end
   assign final_code = decided;

   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg + 6'h01;
      bit_next = bit_reg;
      code_next = code_reg;
      fast_next = fast_reg;
      done = 1'b0;
      case (state_reg)
         sar_adc_pkg::ST_IDLE: begin
            cnt_next = 6'h00;
            if (start) begin
               state_next = sar_adc_pkg::ST_SAMPLE;
               fast_next = fast;
               code_next = '0;
            end
         end
         sar_adc_pkg::ST_SAMPLE: begin
            if (cnt_reg == sar_adc_pkg::sample_len(fast_reg) - 6'h01) begin
               state_next = sar_adc_pkg::ST_TRIAL;
               cnt_next = 6'h00;
               bit_next = 4'(RES_W - 1);
               code_next[RES_W-1] = 1'b1;
            end
         end
         sar_adc_pkg::ST_TRIAL: begin
            if (cnt_reg == sar_adc_pkg::trial_len(fast_reg) - 6'h01) begin
               cnt_next = 6'h00;
               code_next = decided;
               if (bit_reg == 4'h0) begin
                  done = 1'b1;
                  state_next = sar_adc_pkg::ST_IDLE;
               end else begin
                  bit_next = bit_reg - 4'h1;
                  code_next[bit_reg - 4'h1] = 1'b1;
               end
            end
         end
         default: state_next = sar_adc_pkg::ST_IDLE;
      endcase
      if (abort) begin
         state_next = sar_adc_pkg::ST_IDLE;
         done = 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         state_reg <= sar_adc_pkg::ST_IDLE;
         cnt_reg <= 6'h00;
         bit_reg <= 4'h0;
         code_reg <= '0;
         fast_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         bit_reg <= bit_next;
         code_reg <= code_next;
         fast_reg <= fast_next;
      end
   end
endmodule

// ### hdl/trig_edge_sync.sv
`timescale 1ns/100ps
module trig_edge_sync (
   // clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // pin
   input wire logic pin_in,
   // edges of the filtered level
   output logic rise,
   output logic fall
);
   logic [2:0] sync_reg;
   logic level_reg;
   logic stable;

   // level changes only once stages two and three agree
   assign stable = (sync_reg[1] == sync_reg[2]);
   assign rise = stable && sync_reg[2] && !level_reg;
   assign fall = stable && !sync_reg[2] && level_reg;

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         sync_reg <= 3'h0;
         level_reg <= 1'b0;
      end else begin
         sync_reg <= {sync_reg[1:0], pin_in};
         if (stable) begin
            level_reg <= sync_reg[2];
         end
      end
   end
endmodule
